// File: include/period_timer_defines.svh
// Register map, field positions and reset values of the period timer
`ifndef PERIOD_TIMER_DEFINES_SVH
`define PERIOD_TIMER_DEFINES_SVH

// ==========================================================================
// Register offsets, one per timer instance group
`define ADDR_CONTROL      4'h0
`define ADDR_PERIOD       4'h1
`define ADDR_MODE         4'h2
`define ADDR_RESET_SEL    4'h3
`define ADDR_COUNT        4'h4
`define ADDR_PULSE_WIDTH  4'h5
`define ADDR_STATUS       4'h6
`define ADDR_MASK         4'h7
`define ADDR_INST_STRIDE  4'h8

// ==========================================================================
// Control field positions
`define CTRL_RUN_BIT      7
`define CTRL_PRE_MSB      6
`define CTRL_PRE_LSB      4
`define CTRL_POST_MSB     3
`define CTRL_POST_LSB     0

// ==========================================================================
// Reset values and modes
`define CONTROL_RESET     8'h00
`define PERIOD_RESET      8'hff
`define MODE_RESET        5'h00
`define MODE_ONE_SHOT     5'h08
`define STAT_PERIOD_BIT   0
`define STAT_MATCH_BIT    1

`endif

// File: include/period_timer_pkg.sv
// Types shared by the period timer files
package period_timer_pkg;

  typedef logic [7:0] byte_t;

  typedef enum logic [1:0]
  {
    ST_IDLE    = 2'b00,
    ST_RUN     = 2'b01,
    ST_PAUSED  = 2'b10,
    ST_DONE    = 2'b11
  } timer_state_t;

endpackage : period_timer_pkg

// File: src/period_timer_core.sv
// One period timer instance: prescaler, counter, postscaler and PWM drive
`timescale 1ns/100ps
`include "period_timer_defines.svh"

module period_timer_core
(
  input  wire logic                  clock,
  input  wire logic                  reset,
  input  wire logic                  runSet,
  input  wire logic                  runClear,
  input  wire logic [2:0]            prescaleSel,
  input  wire logic [3:0]            postscaleSel,
  input  wire logic [4:0]            modeSel,
  input  wire period_timer_pkg::byte_t periodValue,
  input  wire period_timer_pkg::byte_t pulseWidth,
  input  wire logic                  extReset,
  output logic                       runBit,
  output period_timer_pkg::byte_t    count,
  output logic                       periodEvent,
  output logic                       matchEvent,
  output logic                       pwmDrive
);
  import period_timer_pkg::*;

  // ========================================================================
  // State
  timer_state_t state_r;
  timer_state_t state_nxt;
  logic [6:0]   pre_r;
  logic [3:0]   post_r;
  byte_t        count_r;
  logic         pwm_r;
  logic         run_r;

  wire oneShot   = (modeSel == `MODE_ONE_SHOT);
  wire paused    = (state_r == ST_PAUSED);
  wire counting  = run_r;
  // Divide by 2**code: tick when the low code bits of prescaler all set
  wire [6:0] preMask = 7'((8'h01 << prescaleSel) - 8'h01);
  wire preTick   = counting && ((pre_r & preMask) == preMask);
  wire periodHit = (count_r == periodValue);
  wire wrapTick  = preTick && periodHit;
  wire postHit   = (post_r == postscaleSel);
  wire pwHit     = preTick && (count_r == pulseWidth);
  // Run bit hold-off: a start after the hardware clear is a fresh cycle
  wire freshStart = runSet && !run_r && !paused;
  wire osDone     = oneShot && wrapTick;

  // Cleared run keeps state only while a one-shot cycle is mid-flight
  wire holdReset  = !run_r && !paused;

  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE:   state_nxt = runSet ? ST_RUN : ST_IDLE;
      ST_RUN:
      begin
        if (osDone)
          state_nxt = ST_DONE;
        else if (runClear && oneShot)
          state_nxt = ST_PAUSED;
        else if (runClear)
          state_nxt = ST_IDLE;
      end
      ST_PAUSED: state_nxt = runSet ? ST_RUN : ST_PAUSED;
      ST_DONE:   state_nxt = runSet ? ST_RUN : ST_DONE;
      default:   state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      state_r <= ST_IDLE;
      run_r   <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      // Hardware clear beats the software set in the match cycle
      run_r   <= osDone ? 1'b0 : (runSet | (run_r & ~runClear));
    end
  end

  always_ff @(posedge clock)
  begin
    if (reset || holdReset || (freshStart && state_r == ST_DONE))
    begin
      pre_r   <= 7'h00;
      count_r <= 8'h00;
      post_r  <= 4'h0;
    end
    else if (extReset)
    begin
      pre_r   <= 7'h00;
      count_r <= 8'h00;
    end
    else if (preTick)
    begin
      pre_r   <= 7'h00;
      count_r <= periodHit ? 8'h00 : count_r + 8'h01;
      if (periodHit)
        post_r <= postHit ? 4'h0 : post_r + 4'h1;
    end
    else if (counting)
      pre_r <= pre_r + 7'h01;
  end

  // Drive starts on the run set, ends at the width match; pauses hold it
  always_ff @(posedge clock)
  begin
    if (reset)
      pwm_r <= 1'b0;
    else if (runSet && !paused)
      pwm_r <= 1'b1;
    else if (pwHit)
      pwm_r <= 1'b0;
  end

  assign runBit      = run_r;
  assign count       = count_r;
  assign periodEvent = wrapTick && postHit;
  assign matchEvent  = wrapTick;
  assign pwmDrive    = pwm_r;

endmodule : period_timer_core

// File: src/period_timer_one_shot.sv
// Three period timer instances behind a simple register port
`timescale 1ns/100ps
`include "period_timer_defines.svh"

// Function
// - Eight-bit counter and period, free running or externally controlled.
// - Three-bit prescale code divides clock by two to the code.
// - Four-bit postscale code n gives ratio one to n plus one.
// - Selected external signal resets the count.
// - Mode value 01000 selects software-start one-shot.
// - One-shot period match resets counter and clears run bit.
// - Hardware-cleared run bit is what software reads back.
// - One-shot restarts only when software sets the run bit.
// - New one-shot cycle only after a period-match hardware clear.
// - One-shot clear then set mid-cycle pauses and resumes to completion.
// - PWM drive starts in the cycle the run bit is set.
// - PWM drive ends at width match, stays off until next start.
// - Run bit cleared mid one-shot extends active PWM drive by that time.
// - Three identical instances, each with its own period.
module period_timer_one_shot
#(
  parameter int INSTANCES = 3,
  parameter int RESET_SRCS = 4
)
(
  input  wire logic                  clock,
  input  wire logic                  reset,
  input  wire logic [5:0]            address,
  input  wire period_timer_pkg::byte_t writeData,
  input  wire logic                  writeStrobe,
  input  wire logic                  readStrobe,
  output period_timer_pkg::byte_t    readData,
  input  wire logic [RESET_SRCS-1:0] extResetIn,
  output logic [INSTANCES-1:0]       pwmDrive,
  output logic                       irq
);
  import period_timer_pkg::*;

  // ========================================================================
  // Address split: instance index above, register below
  wire [1:0] instSel = address[4:3];
  wire [2:0] regSel  = address[2:0];
  wire       inRange = (address[5] == 1'b0) && (instSel < 2'(INSTANCES));

  function automatic logic hitReg(input logic [2:0] sel,
                                  input logic [3:0] off);
    hitReg = (sel == off[2:0]);
  endfunction : hitReg

  byte_t readMux [INSTANCES];
  byte_t readData_r;

  // ========================================================================
  // Instances
  genvar g;
  generate
    for (g = 0; g < INSTANCES; g = g + 1)
    begin : gen_inst
      byte_t      control_r;
      byte_t      period_r;
      logic [4:0] mode_r;
      logic [1:0] rstSel_r;
      byte_t      width_r;
      logic [1:0] status_r;
      logic [1:0] mask_r;
      logic       runBit;
      byte_t      count;
      logic       periodEvent;
      logic       matchEvent;

      wire mine   = inRange && (instSel == 2'(g));
      wire wr     = writeStrobe && mine;
      wire wrCtl  = wr && hitReg(regSel, `ADDR_CONTROL);
      wire runSet = wrCtl && writeData[`CTRL_RUN_BIT] && !runBit;
      wire runClr = wrCtl && !writeData[`CTRL_RUN_BIT] && runBit;
      wire [1:0] events = {matchEvent, periodEvent};
      wire [1:0] w1c = (wr && hitReg(regSel, `ADDR_STATUS)) ?
                       writeData[1:0] : 2'b00;

      always_ff @(posedge clock)
      begin
        if (reset)
        begin
          control_r <= `CONTROL_RESET;
          period_r  <= `PERIOD_RESET;
          mode_r    <= `MODE_RESET;
          rstSel_r  <= 2'b00;
          width_r   <= 8'h00;
          status_r  <= 2'b00;
          mask_r    <= 2'b00;
        end
        else
        begin
          if (wrCtl)
            control_r <= writeData;
          if (wr && hitReg(regSel, `ADDR_PERIOD))
            period_r <= writeData;
          if (wr && hitReg(regSel, `ADDR_MODE))
            mode_r <= writeData[4:0];
          if (wr && hitReg(regSel, `ADDR_RESET_SEL))
            rstSel_r <= writeData[1:0];
          if (wr && hitReg(regSel, `ADDR_PULSE_WIDTH))
            width_r <= writeData;
          if (wr && hitReg(regSel, `ADDR_MASK))
            mask_r <= writeData[1:0];
          // Set wins over the write-one clear
          status_r <= (status_r & ~w1c) | events;
        end
      end

      period_timer_core u_core
      (
        .clock        (clock),
        .reset        (reset),
        .runSet       (runSet),
        .runClear     (runClr),
        .prescaleSel  (control_r[`CTRL_PRE_MSB:`CTRL_PRE_LSB]),
        .postscaleSel (control_r[`CTRL_POST_MSB:`CTRL_POST_LSB]),
        .modeSel      (mode_r),
        .periodValue  (period_r),
        .pulseWidth   (width_r),
        .extReset     (extResetIn[rstSel_r]),
        .runBit       (runBit),
        .count        (count),
        .periodEvent  (periodEvent),
        .matchEvent   (matchEvent),
        .pwmDrive     (pwmDrive[g])
      );

      // Run bit reads live state so hardware clears are visible
      wire byte_t ctlRead = {runBit, control_r[6:0]};
      assign readMux[g] =
        hitReg(regSel, `ADDR_CONTROL)     ? ctlRead :
        hitReg(regSel, `ADDR_PERIOD)      ? period_r :
        hitReg(regSel, `ADDR_MODE)        ? {3'b000, mode_r} :
        hitReg(regSel, `ADDR_RESET_SEL)   ? {6'h00, rstSel_r} :
        hitReg(regSel, `ADDR_COUNT)       ? count :
        hitReg(regSel, `ADDR_PULSE_WIDTH) ? width_r :
        hitReg(regSel, `ADDR_STATUS)      ? {6'h00, status_r} :
                                            {6'h00, mask_r};
    end
  endgenerate

  // ========================================================================
  // Interrupt and read port
  logic [INSTANCES-1:0] pend;
  generate
    for (g = 0; g < INSTANCES; g = g + 1)
    begin : gen_irq
      assign pend[g] = |(gen_inst[g].status_r & gen_inst[g].mask_r);
    end
  endgenerate
  assign irq = |pend;

  // Unmapped reads answer zero
  wire byte_t readSel = inRange ? readMux[instSel] : 8'h00;

  always_ff @(posedge clock)
  begin
    if (reset)
      readData_r <= 8'h00;
    else
      readData_r <= readStrobe ? readSel : 8'h00;
  end
  assign readData = readData_r;

endmodule : period_timer_one_shot

// File: test/ext_reset_source.sv
// Model of the external reset signals feeding the timers
`timescale 1ns/100ps
module ext_reset_source
(
  input  wire logic clock,
  output logic [3:0] extResetIn
);
  // ====================
  // Lines idle low; a pulse holds one line high for some cycles
  initial extResetIn = 4'h0;
  // Static task: the line index may steer a non-blocking write
  task pulse(input int line, input int cycles);
    @(posedge clock);
    extResetIn[line] <= 1'b1;
    repeat (cycles) @(posedge clock);
    extResetIn[line] <= 1'b0;
  endtask : pulse
endmodule : ext_reset_source

// File: test/period_timer_checker.sv
// Port-level assertions for the period timer block
`timescale 1ns/100ps
module period_timer_checker
#(
  parameter int INSTANCES  = 3,
  parameter int RESET_SRCS = 4
)
(
  input wire logic                    clock,
  input wire logic                    reset,
  input wire logic [5:0]              address,
  input wire period_timer_pkg::byte_t writeData,
  input wire logic                    writeStrobe,
  input wire logic                    readStrobe,
  input wire period_timer_pkg::byte_t readData,
  input wire logic [RESET_SRCS-1:0]   extResetIn,
  input wire logic [INSTANCES-1:0]    pwmDrive,
  input wire logic                    irq
);
  import period_timer_pkg::*;
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  // ====================
  // Shadows of instance 1 registers, mask ever set
  byte_t ctrlOne_r;
  byte_t perOne_r;
  logic  maskOn_r;
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      ctrlOne_r <= 8'h00;
      perOne_r  <= 8'hff;
      maskOn_r  <= 1'b0;
    end
    else if (writeStrobe)
    begin
      if (address == 6'h08) ctrlOne_r <= writeData;
      if (address == 6'h09) perOne_r <= writeData;
      if (address[2:0] == 3'h7 && writeData != 8'h00) maskOn_r <= 1'b1;
    end
  end
  sequence ctrlOneRead;
    readStrobe && address == 6'h08;
  endsequence
  sequence perOneRead;
    readStrobe && address == 6'h09;
  endsequence
  chk_read_idle: assert property (!readStrobe |=> readData == 8'h00)
    else $error("read data not zero outside a read");
  chk_unmapped_zero: assert property (readStrobe && (address[5] ||
    address[4:3] == 2'b11) |=> readData == 8'h00)
    else $error("unmapped read returned data");
  chk_reset_quiet: assert property ($fell(reset) |-> pwmDrive == '0 && !irq)
    else $error("outputs active after reset");
  chk_irq_masked: assert property (!maskOn_r |-> !irq)
    else $error("irq with every mask bit clear");
  chk_irq_sticky: assert property ($fell(irq) && !$past(reset) |->
    $past(writeStrobe))
    else $error("irq dropped without a write");
  chk_pwm_start: assert property ($rose(pwmDrive[0]) |-> $past(writeStrobe
    && address == 6'h00 && writeData[7]))
    else $error("pwm rose without a run write");
  chk_ctrl_readback: assert property (ctrlOneRead |=>
    readData == $past(ctrlOne_r))
    else $error("control read back wrong");
  chk_period_readback: assert property (perOneRead |=>
    readData == $past(perOne_r))
    else $error("period read back wrong");
endmodule : period_timer_checker

// File: test/testbench.sv
// Self-checking bench for the three period timers
`timescale 1ns/100ps
module testbench;
  import period_timer_pkg::*;
  // ====================
  // Ports and counters
  logic       clock       = 1'b0;
  logic       reset       = 1'b1;
  logic [5:0] address     = 6'h00;
  byte_t      writeData   = 8'h00;
  logic       writeStrobe = 1'b0;
  logic       readStrobe  = 1'b0;
  byte_t      readData;
  logic [3:0] extResetIn;
  logic [2:0] pwmDrive;
  logic       irq;
  byte_t      got;
  int         fail_count  = 0;
  int         comparisons = 0;
  always #12.5 clock = ~clock;
  period_timer_one_shot #(.INSTANCES(3), .RESET_SRCS(4)) dut
  (
    .clock(clock), .reset(reset), .address(address),
    .writeData(writeData), .writeStrobe(writeStrobe),
    .readStrobe(readStrobe), .readData(readData),
    .extResetIn(extResetIn), .pwmDrive(pwmDrive), .irq(irq)
  );
  ext_reset_source partner (.clock(clock), .extResetIn(extResetIn));
  // ====================
  // Bus cycles and compare
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("Error %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [5:0] a, input byte_t d);
    @(posedge clock);
    address     <= a;
    writeData   <= d;
    writeStrobe <= 1'b1;
    @(posedge clock);
    writeStrobe <= 1'b0;
  endtask : wr
  task automatic rd(input logic [5:0] a);
    @(posedge clock);
    address    <= a;
    readStrobe <= 1'b1;
    @(posedge clock);
    readStrobe <= 1'b0;
    #1 got = readData;
  endtask : rd
  task automatic waitIrq(output int n);
    n = 0;
    do
    begin
      @(posedge clock);
      #1 n++;
    end
    while (irq !== 1'b1 && n < 200);
  endtask : waitIrq
  task automatic waitDone();
    int n = 0;
    rd(6'h00);
    while (got[7] !== 1'b0 && n < 80)
    begin
      rd(6'h00);
      n++;
    end
    check(got, 8'h00);
    check(8'(pwmDrive[0]), 8'h00);
    rd(6'h04);
    check(got, 8'h00);
  endtask : waitDone
  // ====================
  // Scenarios
  task automatic regsAndMap();
    rd(6'h01);
    check(got, 8'hff);
    wr(6'h11, 8'h5a);
    wr(6'h20, 8'h33);
    wr(6'h19, 8'h44);
    rd(6'h11);
    check(got, 8'h5a);
    rd(6'h09);
    check(got, 8'hff);
    rd(6'h20);
    check(got, 8'h00);
    rd(6'h19);
    check(got, 8'h00);
  endtask : regsAndMap
  task automatic prescaleAll();
    byte_t a;
    for (int p = 0; p < 8; p++)
    begin
      wr(6'h08, 8'h00);
      wr(6'h08, {1'b1, p[2:0], 4'h0});
      rd(6'h0c);
      a = got;
      repeat ((8 << p) - 2) @(posedge clock);
      rd(6'h0c);
      check(got - a, 8'h08);
      rd(6'h08);
      check(got, {1'b1, p[2:0], 4'h0});
    end
  endtask : prescaleAll
  task automatic postscaleAll();
    int n;
    wr(6'h09, 8'h03);
    wr(6'h0f, 8'h01);
    for (int q = 0; q < 16; q++)
    begin
      wr(6'h08, 8'h00);
      wr(6'h0e, 8'hff);
      wr(6'h08, {4'h8, q[3:0]});
      waitIrq(n);
      wr(6'h0e, 8'h01);
      waitIrq(n);
      check(8'(n + 2), 8'(4 * (q + 1)));
    end
    wr(6'h0f, 8'h00);
    // Mask lands in this edge's update, so look just after it
    #1 check(8'(irq), 8'h00);
    rd(6'h0e);
    check(got & 8'h01, 8'h01);
    wr(6'h08, 8'h00);
  endtask : postscaleAll
  task automatic oneShot();
    wr(6'h02, 8'h08);
    wr(6'h01, 8'h05);
    wr(6'h05, 8'h02);
    for (int k = 0; k < 2; k++)
    begin
      wr(6'h00, 8'h80);
      #1 check(8'(pwmDrive), 8'h01);
      waitDone();
      repeat (10) @(posedge clock);
      rd(6'h04);
      check(got, 8'h00);
    end
  endtask : oneShot
  task automatic pauseResume();
    byte_t a;
    wr(6'h01, 8'h20);
    wr(6'h05, 8'h10);
    wr(6'h00, 8'h80);
    wr(6'h00, 8'h00);
    rd(6'h04);
    a = got;
    repeat (20) @(posedge clock);
    rd(6'h04);
    check(got, a);
    check(8'(pwmDrive[0]), 8'h01);
    wr(6'h00, 8'h80);
    waitDone();
  endtask : pauseResume
  task automatic extResetTest();
    wr(6'h09, 8'hff);
    wr(6'h0b, 8'h02);
    wr(6'h08, 8'h80);
    repeat (40) @(posedge clock);
    partner.pulse(1, 3);
    rd(6'h0c);
    check(8'(got >= 8'd40), 8'h01);
    partner.pulse(2, 3);
    rd(6'h0c);
    check(8'(got < 8'd8), 8'h01);
  endtask : extResetTest
  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : final_report
  initial
  begin
    repeat (8) @(posedge clock);
    reset <= 1'b0;
    regsAndMap();
    prescaleAll();
    postscaleAll();
    oneShot();
    pauseResume();
    extResetTest();
    final_report();
  end
  initial
  begin
    #500000;
    fail_count++;
    final_report();
  end
endmodule : testbench
bind period_timer_one_shot period_timer_checker
  #(.INSTANCES(INSTANCES), .RESET_SRCS(RESET_SRCS)) chk
  (
    .clock(clock), .reset(reset), .address(address),
    .writeData(writeData), .writeStrobe(writeStrobe),
    .readStrobe(readStrobe), .readData(readData),
    .extResetIn(extResetIn), .pwmDrive(pwmDrive), .irq(irq)
  );
